// ===== src/dcdc_pwm_defs.vh
// register offsets, field positions, reset values and timing for the converter controller
`ifndef DCDC_PWM_DEFS_VH
`define DCDC_PWM_DEFS_VH

`define OFF_POWER_DOWN      8'h0e
`define OFF_IND_DATA_LO     8'h1c
`define OFF_IND_DATA_HI     8'h1d
`define OFF_IND_ADDR        8'h1e
`define OFF_IND_STATUS      8'h1f
`define OFF_HEADROOM_RANGE  8'h42
`define OFF_RING_BATTERY    8'h4a
`define OFF_LOW_BATTERY     8'h4b
`define OFF_PWM_PERIOD      8'h5c
`define OFF_SWITCH_DELAY    8'h5d
`define OFF_PULSE_WIDTH     8'h5e
`define OFF_ENHANCE         8'h6c
`define OFF_LINE_STATE      8'h70

`define IND_HEADROOM_OFFSET 8'h29

`define BIT_POWER_OFF       4
`define BIT_CALIBRATE       7
`define BIT_FAST_ERR        5
`define BIT_AUDIO_FILT      1
`define BIT_HEADROOM_RANGE  0
`define BIT_RINGING         0
`define BIT_TRACK           1
`define BIT_CONST_CURRENT   2

`define RST_POWER_DOWN      8'h10
`define RST_PWM_PERIOD      8'hff
`define RST_SWITCH_DELAY    8'h14
`define RST_RING_BATTERY    8'h32
`define RST_LOW_BATTERY     8'h10
`define RST_HEADROOM_OFFSET 4'h2

`define MIN_OFF_EXTRA       8'h04
`define CAL_CYCLES          8'h40
`define HEADROOM_MAX_NARROW 6'h06
`define HEADROOM_MAX_WIDE   6'h09

`endif

// ===== src/dcdc_pwm_battery_controller.v
// pwm controller for the negative battery dc-dc converter with its register file
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dcdc_pwm_defs.vh"

module dcdc_pwm_battery_controller #(
  parameter TRANSFORMER_VARIANT = 0
) (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rdata,
  // converter pins
  output reg        primary_switch_drive,
  output reg        feedforward_switch_drive,
  input  wire       battery_sense_input,
  input  wire       monitor_high_input,
  input  wire       monitor_low_input,
  // loop voltage level from the linefeed, in 1.5 V steps
  input  wire [5:0] loop_voltage_level
);

  // registers
  reg  [7:0] power_down_ff;
  reg        headroom_range_ff;
  reg  [5:0] ring_battery_ff;
  reg  [5:0] low_battery_ff;
  reg  [7:0] period_ff;
  reg  [4:0] min_off_ff;
  reg        calibrate_ff;
  reg  [7:0] cal_cnt_ff;
  reg        fast_err_ff;
  reg        audio_filt_ff;
  reg  [2:0] line_state_ff;
  reg  [3:0] headroom_offset_ff;
  reg  [7:0] ind_addr_ff;
  reg  [7:0] ind_data_ff;
  reg  [7:0] pulse_width_ff;
  reg  [7:0] count_ff;
  reg        drive_ff;
  reg        overload_ff;
  reg  [1:0] cal_ref_ff;
  reg  [3:0] filt_ff;
  reg  [5:0] target_ff;

  wire       power_off;
  wire       ringing;
  wire       track;
  wire       const_curr;
  assign power_off  = power_down_ff[`BIT_POWER_OFF];
  assign ringing    = line_state_ff[`BIT_RINGING];
  assign track      = line_state_ff[`BIT_TRACK];
  assign const_curr = line_state_ff[`BIT_CONST_CURRENT];

  // battery target in 1.5 V steps of magnitude
  reg  [5:0] headroom;
  reg  [5:0] active_tgt;
  reg  [6:0] sum_tgt;
  reg  [5:0] nxt_target;
  always @* begin
    headroom = {2'h0, headroom_offset_ff};
    if (!headroom_range_ff && headroom > `HEADROOM_MAX_NARROW)
      headroom = `HEADROOM_MAX_NARROW;
    else if (headroom_range_ff && headroom > `HEADROOM_MAX_WIDE)
      headroom = `HEADROOM_MAX_WIDE;
    active_tgt = loop_voltage_level;
    if (const_curr && !track && active_tgt < low_battery_ff)
      active_tgt = low_battery_ff;
    sum_tgt = {1'b0, active_tgt} + {1'b0, headroom};
    if (ringing)
      nxt_target = ring_battery_ff;
    else if (sum_tgt[6])
      nxt_target = 6'h3f;
    else
      nxt_target = sum_tgt[5:0];
  end

  wire period_end = (count_ff == period_ff);
  wire overload   = (monitor_high_input | monitor_low_input) & (cal_cnt_ff == 8'h00);
  // audio filter: all four of the last four period samples, or three of them including the newest
  wire [2:0] filt_sum = {2'h0, filt_ff[0]} + {2'h0, filt_ff[1]} +
                        {2'h0, filt_ff[2]} + {2'h0, filt_ff[3]};
  wire below = audio_filt_ff ? filt_sum[2] | (filt_sum == 3'h3) & filt_ff[0]
                             : battery_sense_input;
  // off time is field plus four; width must leave room for it
  wire [7:0] off_time  = {3'h0, min_off_ff} + `MIN_OFF_EXTRA;
  wire [7:0] max_width = (period_ff > off_time) ? period_ff - off_time : 8'h00;
  wire [7:0] step      = fast_err_ff ? ((filt_sum[2] ? 8'h08 : 8'h02)) : 8'h01;

  reg  [7:0] nxt_width;
  always @* begin
    nxt_width = pulse_width_ff;
    if (below) begin
      if (pulse_width_ff > max_width - step || max_width < step)
        nxt_width = max_width;
      else
        nxt_width = pulse_width_ff + step;
    end else begin
      if (pulse_width_ff < step)
        nxt_width = 8'h00;
      else
        nxt_width = pulse_width_ff - step;
    end
    if (nxt_width > max_width)
      nxt_width = max_width;
  end

  // period counter; held at zero while off so switching restarts on a clean period
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= 8'h00;
    end else if (power_off) begin
      count_ff <= 8'h00;
    end else if (period_end) begin
      count_ff <= 8'h00;
    end else begin
      count_ff <= count_ff + 8'h01;
    end
  end

  // sense history and target keep their values while off, so a restart resumes near them
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_ff   <= 4'h0;
      target_ff <= 6'h00;
    end else if (!power_off) begin
      target_ff <= nxt_target;
      if (period_end)
        filt_ff <= {filt_ff[2:0], battery_sense_input};
    end
  end

  // pulse width only moves at a period boundary, except that it is cleared while off
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_width_ff <= 8'h00;
    end else if (power_off) begin
      pulse_width_ff <= 8'h00;
    end else if (period_end) begin
      pulse_width_ff <= nxt_width;
    end
  end

  // switch drive and overload latch
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_ff    <= 1'b0;
      overload_ff <= 1'b0;
    end else if (power_off) begin
      drive_ff    <= 1'b0;
      overload_ff <= 1'b0;
    end else if (period_end) begin
      overload_ff <= overload;
      drive_ff    <= (nxt_width != 8'h00) && !overload;
    end else begin
      if (overload)
        overload_ff <= 1'b1;
      if (overload || count_ff + 8'h01 >= pulse_width_ff)
        drive_ff <= 1'b0;
    end
  end

  // outputs; the transformer part drives the switch from feed-forward only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_switch_drive     <= 1'b0;
      feedforward_switch_drive <= TRANSFORMER_VARIANT ? 1'b0 : 1'b1;
    end else if (TRANSFORMER_VARIANT != 0) begin
      primary_switch_drive     <= 1'b0;
      feedforward_switch_drive <= drive_ff & !overload;
    end else begin
      primary_switch_drive     <= drive_ff & !overload;
      feedforward_switch_drive <= !(drive_ff & !overload);
    end
  end

  // register writes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_down_ff      <= `RST_POWER_DOWN;
      headroom_range_ff  <= 1'b0;
      ring_battery_ff    <= 6'h32;
      low_battery_ff     <= 6'h10;
      period_ff          <= `RST_PWM_PERIOD;
      min_off_ff         <= 5'h14;
      calibrate_ff       <= 1'b0;
      cal_cnt_ff         <= 8'h00;
      fast_err_ff        <= 1'b0;
      audio_filt_ff      <= 1'b0;
      line_state_ff      <= 3'h2;
      headroom_offset_ff <= `RST_HEADROOM_OFFSET;
      ind_addr_ff        <= 8'h00;
      ind_data_ff        <= 8'h00;
      cal_ref_ff         <= 2'h0;
    end else begin
      // calibration runs a fixed window while monitor inputs are ignored
      if (cal_cnt_ff != 8'h00) begin
        cal_cnt_ff <= cal_cnt_ff - 8'h01;
        cal_ref_ff <= {monitor_high_input, monitor_low_input};
        if (cal_cnt_ff == 8'h01)
          calibrate_ff <= 1'b0;
      end
      if (wr_en) begin
        case (addr)
          `OFF_POWER_DOWN: begin
            power_down_ff <= wdata;
          end
          `OFF_HEADROOM_RANGE: begin
            headroom_range_ff <= wdata[`BIT_HEADROOM_RANGE];
          end
          `OFF_RING_BATTERY: begin
            ring_battery_ff <= wdata[5:0];
          end
          `OFF_LOW_BATTERY: begin
            low_battery_ff <= wdata[5:0];
          end
          `OFF_PWM_PERIOD: begin
            period_ff <= wdata;
          end
          `OFF_SWITCH_DELAY: begin
            min_off_ff <= wdata[4:0];
            if (wdata[`BIT_CALIBRATE] && !power_off) begin
              calibrate_ff <= 1'b1;
              cal_cnt_ff   <= `CAL_CYCLES;
            end
          end
          `OFF_ENHANCE: begin
            fast_err_ff   <= wdata[`BIT_FAST_ERR];
            audio_filt_ff <= wdata[`BIT_AUDIO_FILT];
          end
          `OFF_LINE_STATE: begin
            line_state_ff <= wdata[2:0];
          end
          `OFF_IND_DATA_LO: begin
            ind_data_ff <= wdata;
          end
          `OFF_IND_ADDR: begin
            ind_addr_ff <= wdata;
            if (wdata == `IND_HEADROOM_OFFSET)
              headroom_offset_ff <= ind_data_ff[3:0];
          end
          default: ;
        endcase
      end
    end
  end

  // register reads, one cycle later; unmapped reads return zero so that
  // software probing the map never sees a neighbour's stale value
  reg  [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = 8'h00;
    case (addr)
      `OFF_POWER_DOWN: begin
        nxt_rdata = power_down_ff;
      end
      `OFF_HEADROOM_RANGE: begin
        nxt_rdata = {7'h00, headroom_range_ff};
      end
      `OFF_RING_BATTERY: begin
        nxt_rdata = {2'h0, ring_battery_ff};
      end
      `OFF_LOW_BATTERY: begin
        nxt_rdata = {2'h0, low_battery_ff};
      end
      `OFF_PWM_PERIOD: begin
        nxt_rdata = period_ff;
      end
      `OFF_SWITCH_DELAY: begin
        nxt_rdata = {calibrate_ff, 2'h0, min_off_ff};
      end
      `OFF_PULSE_WIDTH: begin
        nxt_rdata = pulse_width_ff;
      end
      `OFF_ENHANCE: begin
        nxt_rdata = {2'h0, fast_err_ff, 3'h0, audio_filt_ff, 1'b0};
      end
      `OFF_LINE_STATE: begin
        nxt_rdata = {2'h0, target_ff} | {line_state_ff, 5'h00};
      end
      `OFF_IND_DATA_LO: begin
        if (ind_addr_ff == `IND_HEADROOM_OFFSET)
          nxt_rdata = {4'h0, headroom_offset_ff};
      end
      `OFF_IND_DATA_HI: begin
        nxt_rdata = 8'h00;
      end
      `OFF_IND_ADDR: begin
        nxt_rdata = ind_addr_ff;
      end
      `OFF_IND_STATUS: begin
        nxt_rdata = 8'h00;
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // read data holds between reads
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= nxt_rdata;
    end
  end

endmodule
`default_nettype wire

// ===== sim/dcdc_pwm_checker.sv
// port assertions for the converter controller
`timescale 1ns/10ps
`default_nettype none
module dcdc_chk #(parameter TRANSFORMER_VARIANT = 0) (
  // clock, reset and registers
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  // converter pins
  input wire logic       primary_switch_drive,
  input wire logic       feedforward_switch_drive,
  input wire logic       monitor_high_input,
  input wire logic       monitor_low_input
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_rd(a);
    wr_en && addr == a ##1 rd_en && addr == a;
  endsequence
  property echo(a);
    wr_rd(a) |=> rdata[5:0] == $past(wdata[5:0], 2);
  endproperty
  a_ff_inverse: assert property (TRANSFORMER_VARIANT != 0 ||
    feedforward_switch_drive != primary_switch_drive) else $error("ff polarity");
  a_overload_cut: assert property (monitor_high_input || monitor_low_input
    |-> ##2 !primary_switch_drive) else $error("drive in overload");
  a_min_off: assert property ($fell(primary_switch_drive)
    |-> !primary_switch_drive [*4]) else $error("off time short");
  a_power_off: assert property (wr_en && addr == 8'h0e && wdata[4]
    |-> ##3 !primary_switch_drive [*8]) else $error("drive when off");
  a_rdata_hold: assert property (!$past(rd_en) |-> $stable(rdata))
    else $error("rdata moved");
  a_period_echo: assert property (echo(8'h5c)) else $error("period readback");
  a_ring_echo: assert property (echo(8'h4a)) else $error("ring readback");
  a_low_echo: assert property (echo(8'h4b)) else $error("low readback");
endmodule
bind dcdc_pwm_battery_controller dcdc_chk #(.TRANSFORMER_VARIANT(TRANSFORMER_VARIANT)) c_u (.*);
`default_nettype wire

// ===== sim/converter_plant.sv
// battery sense network behind the converter
`timescale 1ns/10ps
`default_nettype none
module converter_plant #(parameter int TARGET = 40) (
  // switch drive in, sense out
  input  wire logic clk,
  input  wire logic primary_switch_drive,
  output wire logic battery_sense_input
);
  int level = 0;
  // on cycles charge the output, off cycles let the load drain it
  always @(posedge clk)
    if (primary_switch_drive) level <= level + 2;
    else if (level > 0) level <= level - 1;
  assign battery_sense_input = level < TARGET;
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the converter controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic monitor_high_input = 1'b0, monitor_low_input = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, v;
  logic [5:0] loop_voltage_level = 6'h00;
  wire logic [7:0] rdata;
  wire logic primary_switch_drive, feedforward_switch_drive, battery_sense_input;
  wire logic [7:0] pins = {6'h0, primary_switch_drive, feedforward_switch_drive};
  int miscompares = 0, comparisons = 0, highs = 0;
  logic [7:0] ra [6] = '{8'h0e, 8'h5c, 8'h5d, 8'h4a, 8'h4b, 8'h00};
  logic [7:0] rv [6] = '{8'h10, 8'hff, 8'h14, 8'h32, 8'h10, 8'h00};
  logic [7:0] wa [5] = '{8'h5d, 8'h5c, 8'h4b, 8'h4a, 8'h6c};
  logic [7:0] wv [5] = '{8'h02, 8'h40, 8'h0c, 8'h3f, 8'h22};
  dcdc_pwm_battery_controller dut_u (.*);
  converter_plant plant_u (.*);
  initial forever #20 clk = ~clk;
  always @(posedge clk)
    if (primary_switch_drive) highs <= highs + 1;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // called on a rising edge; strobe is one cycle, read data taken in the cycle after
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic idle(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ra[i]) begin
      acc(1'b0, ra[i], 8'h00);
      chk("reset value", v, rv[i]);
    end
    foreach (wa[i]) begin
      acc(1'b1, wa[i], wv[i]);
      acc(1'b0, wa[i], 8'h00);
      chk("readback", v, wv[i]);
    end
    chk("pins off", pins, 8'h01);
    acc(1'b1, 8'h0e, 8'h00);
    idle(1500);
    chk("pulses on", {7'h0, highs > 0}, 8'h01);
    acc(1'b0, 8'h5e, 8'h00);
    chk("width cap", {7'h0, v <= 8'h3a}, 8'h01);
    monitor_high_input <= 1'b1;
    idle(3);
    chk("overload", pins, 8'h01);
    monitor_high_input <= 1'b0;
    acc(1'b1, 8'h5d, 8'h82);
    acc(1'b0, 8'h5d, 8'h00);
    chk("calibrating", {7'h0, v[7]}, 8'h01);
    idle(70);
    acc(1'b0, 8'h5d, 8'h00);
    chk("calibrated", v, 8'h02);
    acc(1'b1, 8'h1c, 8'h05);
    acc(1'b1, 8'h1e, 8'h29);
    acc(1'b0, 8'h1c, 8'h00);
    chk("headroom", v, 8'h05);
    acc(1'b1, 8'h70, 8'h01);
    acc(1'b0, 8'h70, 8'h00);
    chk("ring target", v, 8'h3f);
    acc(1'b1, 8'h70, 8'h04);
    acc(1'b0, 8'h70, 8'h00);
    chk("no track floor", v, 8'h91);
    acc(1'b1, 8'h70, 8'h00);
    acc(1'b0, 8'h70, 8'h00);
    chk("active target", v, 8'h05);
    acc(1'b1, 8'h0e, 8'h10);
    idle(4);
    chk("pins off", pins, 8'h01);
    final_report;
  end
endmodule
`default_nettype wire
